// File: core/pg_route_regs.sv
// APB register bank routing the port G analog switches
`timescale 1ns/1ps
module pg_route_regs
  import pg_route_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [15:0]          switch_timer_ctrl,
  output logic      [15:0]          channel_unmasked,
  output logic      [15:0]          sample_cap_io,
  output logic      [31:0]          capture_route_sel
);
  import pg_route_pkg::*;

  logic [15:0]   switch_mode_ff;
  logic [15:0]   channel_mask_ff;
  logic [15:0]   capture_ident_ff;
  logic [31:0]   route_select_ff;
  logic [31:0]   prdata_ff;
  logic          wr_en;
  logic          rd_en;
  logic          addr_hit;
  pin_route_type route;

  // Word-aligned decode; low two bits ignored by design
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : is_reg

  // Merge byte lanes of write data into an old value
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : lane16

  // Zero-wait slave, one access cycle per transfer
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign addr_hit = is_reg(paddr, OFF_CAPTURE_ROUTE) | is_reg(paddr, OFF_SWITCH_MODE) |
                    is_reg(paddr, OFF_CHANNEL_MASK) | is_reg(paddr, OFF_CAPTURE_IDENT);
  // Unmapped address answers with an error, no state change
  assign pslverr = psel & penable & ~addr_hit;

  // Port G fields; upper half of pwdata never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_mode_ff   <= PIN_RESET;
      channel_mask_ff  <= PIN_RESET;
      capture_ident_ff <= PIN_RESET;
    end else if (wr_en) begin
      if (is_reg(paddr, OFF_SWITCH_MODE)) begin
        switch_mode_ff <= lane16(switch_mode_ff, pwdata, pstrb);
      end else if (is_reg(paddr, OFF_CHANNEL_MASK)) begin
        channel_mask_ff <= lane16(channel_mask_ff, pwdata, pstrb);
      end else if (is_reg(paddr, OFF_CAPTURE_IDENT)) begin
        capture_ident_ff <= lane16(capture_ident_ff, pwdata, pstrb);
      end
    end
  end

  // Capture route select kept as a plain full word, passed out for the timer side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_select_ff <= ROUTE_SELECT_RESET;
    end else if (wr_en && is_reg(paddr, OFF_CAPTURE_ROUTE)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          route_select_ff[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  // Read data captured in setup phase so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= READ_ZERO;
    end else if (rd_en) begin
      if (is_reg(paddr, OFF_SWITCH_MODE)) begin
        prdata_ff <= {16'h0000, switch_mode_ff};
      end else if (is_reg(paddr, OFF_CHANNEL_MASK)) begin
        prdata_ff <= {16'h0000, channel_mask_ff};
      end else if (is_reg(paddr, OFF_CAPTURE_IDENT)) begin
        prdata_ff <= {16'h0000, capture_ident_ff};
      end else if (is_reg(paddr, OFF_CAPTURE_ROUTE)) begin
        prdata_ff <= route_select_ff;
      end else begin
        prdata_ff <= READ_ZERO;
      end
    end
  end
  assign prdata = prdata_ff;

  pg_route_decode u_decode (
    .switch_mode   (switch_mode_ff),
    .channel_mask  (channel_mask_ff),
    .capture_ident (capture_ident_ff),
    .route         (route)
  );

  // Matrix controls from register bits; sampling-capacitor marks gated by switch mode
  assign switch_timer_ctrl = route.timer_ctrl;
  assign channel_unmasked  = route.unmasked;
  assign sample_cap_io     = route.sample_cap;
  assign capture_route_sel = route_select_ff;

  // Routing outputs back at zero on the first edge after any reset release
  reset_zero_a: assert property (@(posedge pclk) $rose(presetn) |->
    (switch_timer_ctrl == PIN_RESET && channel_unmasked == PIN_RESET && sample_cap_io == PIN_RESET))
    else $error("routing outputs not zero after reset");

  // Route select and read data also cleared, so a mid-run reset leaves nothing stale
  reset_route_a: assert property (@(posedge pclk) $rose(presetn) |->
    capture_route_sel == ROUTE_SELECT_RESET && prdata == READ_ZERO)
    else $error("route select or read data not zero after reset");

  // Full-word mode write lands in the switch control outputs
  mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, OFF_SWITCH_MODE) && pstrb == 4'hf |=> switch_timer_ctrl == $past(pwdata[15:0]))
    else $error("switch mode write lost");

  // Switch control output follows the stored mode bits at all times
  mode_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    switch_timer_ctrl == switch_mode_ff)
    else $error("switch control differs from mode register");

  // Full-word mask write lands in the unmask outputs
  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, OFF_CHANNEL_MASK) && pstrb == 4'hf |=> channel_unmasked == $past(pwdata[15:0]))
    else $error("channel mask write lost");

  // Unmask output never inverted or delayed against the register
  mask_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    channel_unmasked == channel_mask_ff)
    else $error("unmask output differs from mask register");

  // High lane alone updates the high byte and keeps the low byte
  lane_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, OFF_CHANNEL_MASK) && pstrb[1:0] == 2'b10 |=>
    channel_mask_ff == {$past(pwdata[15:8]), $past(channel_mask_ff[7:0])})
    else $error("byte lane merge wrong");

  // Full-word ident write lands in the stored ident bits
  ident_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, OFF_CAPTURE_IDENT) && pstrb == 4'hf |=> capture_ident_ff == $past(pwdata[15:0]))
    else $error("capture ident write lost");

  // Sampling-capacitor marks are the ident bits of timer-controlled pins
  ident_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_cap_io == (capture_ident_ff & switch_timer_ctrl))
    else $error("capture ident not gated by timer mode");

  // No sampling-capacitor mark on a pin left to the converter side
  ident_only_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_cap_io & ~switch_timer_ctrl) == 16'h0000)
    else $error("capture ident active without timer mode");

  // Full-word route select write lands whole
  route_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && is_reg(paddr, OFF_CAPTURE_ROUTE) && pstrb == 4'hf |=> capture_route_sel == $past(pwdata))
    else $error("route select write lost");

  // Mask readback stands in the access cycle
  readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && is_reg(paddr, OFF_CHANNEL_MASK) ##1 penable |-> prdata[15:0] == channel_mask_ff)
    else $error("mask readback mismatch");

  // Mode readback stands in the access cycle
  mode_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && is_reg(paddr, OFF_SWITCH_MODE) ##1 penable |-> prdata[15:0] == switch_mode_ff)
    else $error("mode readback mismatch");

  // Ident readback shows the raw bits, not the gated ones
  ident_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && is_reg(paddr, OFF_CAPTURE_IDENT) ##1 penable |-> prdata[15:0] == capture_ident_ff)
    else $error("ident readback mismatch");

  // Route select reads back as the full stored word
  route_readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && is_reg(paddr, OFF_CAPTURE_ROUTE) ##1 penable |-> prdata == route_select_ff)
    else $error("route select readback mismatch");

  // Port G fields change only on a write
  hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(switch_mode_ff) && $stable(channel_mask_ff) && $stable(capture_ident_ff))
    else $error("register changed without write");

  // Route select changes only on a write
  route_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(route_select_ff))
    else $error("route select changed without write");

  // Reserved half of the port G words always reads zero
  upper_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && !is_reg(paddr, OFF_CAPTURE_ROUTE) ##1 psel && penable |-> prdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  // Strobes on the reserved lanes alone leave the three port G fields alone
  upper_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[1:0] == 2'b00 |=> $stable(switch_mode_ff) && $stable(channel_mask_ff) && $stable(capture_ident_ff))
    else $error("upper-lane write changed a field");

  // Unmapped read returns zero in its access cycle
  unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && !addr_hit ##1 penable |-> prdata == READ_ZERO)
    else $error("unmapped read not zero");

  // Error answer comes with no state change anywhere
  err_no_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |=> $stable(switch_mode_ff) && $stable(channel_mask_ff) && $stable(capture_ident_ff) &&
    $stable(route_select_ff))
    else $error("erroring access changed a register");

  // Main scenarios: timer control, capture pins, re-masking, bad address, strobed writes
  timer_mode_c: cover property (@(posedge pclk) disable iff (!presetn) switch_timer_ctrl != 16'h0000);
  sample_cap_c: cover property (@(posedge pclk) disable iff (!presetn) sample_cap_io != 16'h0000);
  remask_c:     cover property (@(posedge pclk) disable iff (!presetn)
    $fell(channel_unmasked[0]) && switch_timer_ctrl[0] == 1'b1);
  bad_addr_c:   cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  lane_write_c: cover property (@(posedge pclk) disable iff (!presetn) wr_en && pstrb != 4'hf);
endmodule : pg_route_regs

// File: core/pg_route_pkg.sv
// Package: register map, reset values and carrier types for the port G routing registers
// Overview of operation
// - Switch-mode bit set: pin switch follows timer compare; clear: converter or switch-control regs.
// - Channel-mask bit clear masks that pin during acquisition; set leaves it unmasked.
// - Capture-ident bit clear marks channel I/O; set marks sampling-capacitor I/O.
// - All sixteen fields of three registers are read/write and reset to zero.
// - Capture identification takes effect only while the pin is under timer compare control.
package pg_route_pkg;

  localparam int          ADDR_W              = 8;
  localparam int          PIN_N               = 16;
  localparam logic [7:0]  OFF_CAPTURE_ROUTE   = 8'h00;
  localparam logic [7:0]  OFF_SWITCH_MODE     = 8'h4c;
  localparam logic [7:0]  OFF_CHANNEL_MASK    = 8'h50;
  localparam logic [7:0]  OFF_CAPTURE_IDENT   = 8'h54;
  localparam logic [15:0] PIN_RESET           = 16'h0000;
  localparam logic [31:0] ROUTE_SELECT_RESET  = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

  // Per-pin routing state handed to the switch matrix
  typedef struct packed {
    logic [15:0] timer_ctrl;
    logic [15:0] unmasked;
    logic [15:0] sample_cap;
  } pin_route_type;

endpackage : pg_route_pkg

// File: core/pg_route_decode.sv
// Routing decode: turns the three per-pin register fields into matrix controls
`timescale 1ns/1ps
module pg_route_decode
  import pg_route_pkg::*;
(
  input  wire logic [15:0]          switch_mode,
  input  wire logic [15:0]          channel_mask,
  input  wire logic [15:0]          capture_ident,
  output pg_route_pkg::pin_route_type route
);
  import pg_route_pkg::*;

  // Pure wiring plus gating, registered copies live in the parent
  always_comb begin
    route.timer_ctrl = switch_mode;
    route.unmasked   = channel_mask;
    route.sample_cap = capture_ident & switch_mode;
  end
endmodule : pg_route_decode

// File: sim/pg_matrix_model.sv
// Far-side model: switch matrix and timer capture arming
`timescale 1ns/1ps
module pg_matrix_model
  import pg_route_pkg::*;
(
  input  wire logic [15:0] switch_timer_ctrl,
  input  wire logic [15:0] channel_unmasked,
  input  wire logic [15:0] sample_cap_io,
  output logic      [15:0] capture_armed
);
  // Capture only on unmasked sampling pins; masking stops a repeat detection
  assign capture_armed = sample_cap_io & channel_unmasked & switch_timer_ctrl;
endmodule : pg_matrix_model

// File: sim/pg_route_regs_tb_top.sv
// Testbench for the port G routing register bank
`timescale 1ns/1ps
module pg_route_regs_tb_top;
  import pg_route_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic [3:0]  strb = 4'hf;
  logic [31:0] prdata, capture_route_sel, rd, v, w;
  logic [15:0] switch_timer_ctrl, channel_unmasked, sample_cap_io, capture_armed, s, c, i;
  logic        pready, pslverr, err;
  int          bad_count = 0;
  int          comparisons = 0;
  integer      seed = 66531;

  always #20 pclk = ~pclk;

  pg_route_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_timer_ctrl(switch_timer_ctrl), .channel_unmasked(channel_unmasked),
    .sample_cap_io(sample_cap_io), .capture_route_sel(capture_route_sel));
  pg_matrix_model i_far (.switch_timer_ctrl(switch_timer_ctrl), .channel_unmasked(channel_unmasked),
    .sample_cap_io(sample_cap_io), .capture_armed(capture_armed));

  function automatic logic [15:0] exp_cap(input logic [15:0] m, input logic [15:0] d);
    return m & d;
  endfunction : exp_cap

  // Strobed write result: lanes with a strobe take the new byte
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction : lanes

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Writes the three pin registers, hi lands in the reserved half
  task load(input logic [15:0] m, input logic [15:0] k, input logic [15:0] d, input logic [15:0] hi);
    apb(1'b1, OFF_SWITCH_MODE, {hi, m});
    apb(1'b1, OFF_CHANNEL_MASK, {hi, k});
    apb(1'b1, OFF_CAPTURE_IDENT, {hi, d});
    chk(32'(switch_timer_ctrl), 32'(m));
    chk(32'(channel_unmasked), 32'(k));
    chk(32'(sample_cap_io), 32'(exp_cap(m, d)));
    chk(32'(capture_armed), 32'(exp_cap(m, d) & k));
    apb(1'b0, OFF_SWITCH_MODE, 32'h0000_0000);
    chk(rd, 32'(m));
    apb(1'b0, OFF_CHANNEL_MASK, 32'h0000_0000);
    chk(rd, 32'(k));
    apb(1'b0, OFF_CAPTURE_IDENT, 32'h0000_0000);
    chk(rd, 32'(d));
    chk(32'(err), 32'h0000_0000);
  endtask : load

  task print_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the roughly one thousand cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge pclk);
    chk({switch_timer_ctrl, channel_unmasked}, 32'h0000_0000);
    presetn <= 1'b1;
    apb(1'b0, OFF_CAPTURE_IDENT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int n = 0; n < 40; n++) begin
      s = 16'($random(seed));
      c = 16'($random(seed));
      i = 16'($random(seed));
      load(s, c, i, 16'h0000);
    end
    load(16'hffff, 16'h0000, 16'hffff, 16'hffff);
    load(16'h00ff, 16'hffff, 16'hf0f0, 16'h0000);
    load(16'h0001, 16'h0000, 16'h0001, 16'h0000);
    v = 32'($random(seed));
    apb(1'b1, OFF_CAPTURE_ROUTE, v);
    chk(capture_route_sel, v);
    apb(1'b0, OFF_CAPTURE_ROUTE, 32'h0000_0000);
    chk(rd, v);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // Mid-run reset with fields still set must clear everything
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({switch_timer_ctrl, channel_unmasked}, 32'h0000_0000);
    chk(32'(sample_cap_io), 32'h0000_0000);
    chk(capture_route_sel, 32'h0000_0000);
    presetn <= 1'b1;
    // Random byte strobes; reserved lanes alone must change nothing
    c = 16'h0000;
    v = 32'h0000_0000;
    for (int n = 0; n < 24; n++) begin
      strb = 4'($random(seed));
      w = 32'($random(seed));
      apb(1'b1, OFF_CHANNEL_MASK, {16'h0000, w[15:0]});
      c = 16'(lanes({16'h0000, c}, {16'h0000, w[15:0]}, strb));
      chk(32'(channel_unmasked), 32'(c));
      apb(1'b1, OFF_CAPTURE_ROUTE, w);
      v = lanes(v, w, strb);
      chk(capture_route_sel, v);
    end
    strb = 4'hf;
    print_verdict();
  end
endmodule : pg_route_regs_tb_top
